// [design/hrc_pkg.sv]
// Purpose: constants for the hardware reset controller
// Assumes: 32-bit classic wishbone, word-aligned registers
// Notes:   register byte address is four times its index

package hrc_pkg;

  // =========================================
  // register indices (byte address = 4 * index)
  localparam logic [9:0] PULL_UP_CONTROL_2_IDX = 10'h3fe;
  localparam logic [9:0] PM0_IDX  = 10'h3f0;
  localparam logic [9:0] STAT_IDX = 10'h3f1;
  localparam logic [9:0] PCR_IDX  = 10'h3f2;

  // =========================================
  // reset values and field layout
  localparam logic [7:0] PULL_UP_CONTROL_2_LOW  = 8'h00;
  localparam logic [7:0] PULL_UP_CONTROL_2_HIGH = 8'h02;
  localparam logic [7:0] PCR_RST   = 8'h00;
  localparam logic [1:0] PM_SINGLE = 2'h0;
  localparam logic [1:0] PM_EXPAND = 2'h1;
  localparam logic [1:0] PM_MPROC  = 2'h3;
  localparam int         PM_SWR_B  = 3;
  localparam int         ST_RAM_B  = 3;

  // reset cause codes, held in status bits 2:0
  localparam logic [2:0] CAUSE_PIN = 3'h1;
  localparam logic [2:0] CAUSE_BOR = 3'h2;
  localparam logic [2:0] CAUSE_SW  = 3'h3;
  localparam logic [2:0] CAUSE_WDT = 3'h4;
  localparam logic [2:0] CAUSE_OSD = 3'h5;

  // =========================================
  // timing: internal resets hold for a fixed time
  localparam int CLK_MHZ      = 250;
  localparam int SOFT_HOLD_NS = 40;
  localparam int SOFT_HOLD_CY = (SOFT_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int XIN_MIN_CY   = 20;

  // address decode result
  typedef enum logic [2:0] {
    HRC_R_PULL_UP_CONTROL_2 = 3'b000,
    HRC_R_PM0  = 3'b001,
    HRC_R_STAT = 3'b010,
    HRC_R_PCR  = 3'b011,
    HRC_R_NONE = 3'b100
  } hrc_reg_t;

  // sequencer states
  typedef enum logic [1:0] {
    HRC_RUN   = 2'b00,
    HRC_HOLD  = 2'b01,
    HRC_REL   = 2'b10,
    HRC_FETCH = 2'b11
  } hrc_state_t;

endpackage

// [design/hrc_reset_ctrl.sv]
// Purpose: reset sequencer with pull-up and mode registers
// Assumes: inputs synchronous to clk_i, pin input still synchronised
// Notes:   internal ram is never touched by this block
//
// Behaviour
// RQ1: five sources reset the chip: pin, brown-out, software, watchdog and oscillation stop.
// RQ2: a pin or brown-out reset loads pull-up control 2 with 00h or 02h by the boot-mode pin.
// RQ3: a software, watchdog or oscillation-stop reset loads it 00h in single-chip mode, else 02h; the code also loads 00h when the mode field is 2h.
// RQ4: reserved register locations cannot be reached by software.
// RQ5: while the reset pin is low every pin is forced to its reset state.
// RQ6: while the reset pin is low the oscillator is reset, and the main clock then runs.
// RQ7: cpu and registers are reset when the reset pin goes from low to high.
// RQ8: after release execution starts at the reset vector.
// RQ9: a pin reset leaves internal ram contents unchanged.
// RQ10: a pin reset during a ram write marks ram contents as indeterminate.
// RQ11: the outside holds the pin low for at least 20 input clocks before raising it.
// RQ12: the pin release is synchronised to the internal clock before cpu reset is released.

`timescale 1ns/10ps

module hrc_reset_ctrl
  import hrc_pkg::*;
#(
  parameter int               VEC_W      = 20,
  parameter logic [VEC_W-1:0] RESET_VEC  = 20'hffffc
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             reset_pin_n_i,
  input  wire logic             boot_mode_pin_i,
  input  wire logic             brownout_i,
  input  wire logic             wdt_reset_i,
  input  wire logic             osc_stop_i,
  input  wire logic             ram_wr_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [11:0]      adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  output logic                  err_o,
  output logic                  pin_reset_o,
  output logic                  osc_reset_o,
  output logic                  osc_run_o,
  output logic                  cpu_reset_o,
  output logic                  sfr_reset_o,
  output logic                  fetch_o,
  output logic      [VEC_W-1:0] fetch_addr_o,
  output logic      [7:0]       pull_up_control_2_o,
  output logic      [7:0]       port_control_o,
  output logic      [1:0]       processor_mode_field_o,
  output logic                  ram_indet_o
);

  // =========================================
  // helpers
  function automatic hrc_reg_t reg_dec(input logic [9:0] idx);
    case (idx)
      PULL_UP_CONTROL_2_IDX: reg_dec = HRC_R_PULL_UP_CONTROL_2;
      PM0_IDX:  reg_dec = HRC_R_PM0;
      STAT_IDX: reg_dec = HRC_R_STAT;
      PCR_IDX:  reg_dec = HRC_R_PCR;
      default:  reg_dec = HRC_R_NONE;
    endcase
  endfunction

  // =========================================
  // pin synchroniser
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s1_d;
  logic pin_s2_d;

  // RQ12: two-stage release sync
  always_comb
  begin
    pin_s1_d = reset_pin_n_i;
    pin_s2_d = pin_s1_q;
  end

  // reset value low: treat pin as asserted until sampled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  // =========================================
  // sequencer
  hrc_state_t state_q;
  hrc_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       hard_q;
  logic       hard_d;
  logic [2:0] cause_q;
  logic [2:0] cause_d;
  logic       hard_req;
  logic       soft_req;
  logic       sw_rst_q;

  // RQ1: pin and brown-out are levels, others one-shot
  assign hard_req = ~pin_s2_q | brownout_i;
  assign soft_req = sw_rst_q | wdt_reset_i | osc_stop_i;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    hard_d  = hard_q;
    cause_d = cause_q;
    case (state_q)
      HRC_RUN:
      begin
        // RQ1: hardware sources take priority
        if (hard_req)
        begin
          state_d = HRC_HOLD;
          hard_d  = 1'b1;
          cnt_d   = 8'h00;
          cause_d = brownout_i ? CAUSE_BOR : CAUSE_PIN;
        end
        else if (soft_req)
        begin
          state_d = HRC_HOLD;
          hard_d  = 1'b0;
          cnt_d   = 8'(SOFT_HOLD_CY - 1);
          cause_d = sw_rst_q ? CAUSE_SW : (wdt_reset_i ? CAUSE_WDT : CAUSE_OSD);
        end
      end
      HRC_HOLD:
      begin
        // RQ7: cpu released only after pin is seen high
        if (hard_req)
        begin
          hard_d = 1'b1;
          cnt_d  = 8'h00;
          if (brownout_i)
            cause_d = CAUSE_BOR;
          else if (!hard_q)
            cause_d = CAUSE_PIN;
        end
        else if (cnt_q == 8'h00)
          state_d = HRC_REL;
        else
          cnt_d = cnt_q - 8'h01;
      end
      HRC_REL:
        state_d = hard_req ? HRC_HOLD : HRC_FETCH;
      HRC_FETCH:
        state_d = HRC_RUN;
      default:
        state_d = HRC_HOLD;
    endcase
  end

  // sync reset behaves as a pin reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= HRC_HOLD;
      cnt_q   <= 8'h00;
      hard_q  <= 1'b1;
      cause_q <= CAUSE_PIN;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hard_q  <= hard_d;
      cause_q <= cause_d;
    end
  end

  // =========================================
  // reset outputs, decoded from state flops
  // RQ5: pins held while any reset is in force
  assign pin_reset_o = (state_q == HRC_HOLD) | (state_q == HRC_REL);
  // RQ6: oscillator reset while pin low, free-running otherwise
  assign osc_reset_o = (state_q == HRC_HOLD) & ~pin_s2_q;
  assign osc_run_o   = ~osc_reset_o;
  // RQ7: cpu held through release cycle, sfr strobe on release
  assign cpu_reset_o = (state_q != HRC_RUN) & (state_q != HRC_FETCH);
  assign sfr_reset_o = (state_q == HRC_REL);
  // RQ8: vector fetch strobe one cycle after release
  assign fetch_o     = (state_q == HRC_FETCH);

  // =========================================
  // registers and wishbone slave
  logic [7:0]       pull_up_control_2_q;
  logic [7:0]       pull_up_control_2_d;
  logic [7:0]       pcr_q;
  logic [7:0]       pcr_d;
  logic [1:0]       pm_q;
  logic [1:0]       pm_d;
  logic             sw_rst_d;
  logic             ram_q;
  logic             ram_d;
  logic [VEC_W-1:0] vec_q;
  logic [VEC_W-1:0] vec_d;
  logic             ack_q;
  logic             ack_d;
  logic             err_q;
  logic             err_d;
  logic [31:0]      dat_q;
  logic [31:0]      dat_d;
  logic [7:0]       pull_up_control_2_rst;
  logic             req;
  logic             wr_lo;
  hrc_reg_t         sel_reg;

  assign req     = cyc_i & stb_i & ~ack_q & ~err_q;
  assign sel_reg = reg_dec(adr_i[11:2]);
  assign wr_lo   = req & we_i & sel_i[0];

  // pull-up value chosen by reset kind
  always_comb
  begin
    // RQ2: hardware resets follow boot-mode pin
    if (hard_q)
      pull_up_control_2_rst = boot_mode_pin_i ? PULL_UP_CONTROL_2_HIGH : PULL_UP_CONTROL_2_LOW;
    // RQ3: soft resets follow processor mode
    else if (pm_q == PM_EXPAND || pm_q == PM_MPROC)
      pull_up_control_2_rst = PULL_UP_CONTROL_2_HIGH;
    else
      pull_up_control_2_rst = PULL_UP_CONTROL_2_LOW;
  end

  always_comb
  begin
    pull_up_control_2_d   = pull_up_control_2_q;
    pcr_d    = pcr_q;
    pm_d     = pm_q;
    sw_rst_d = sw_rst_q;
    ram_d    = ram_q;
    vec_d    = vec_q;
    ack_d    = 1'b0;
    err_d    = 1'b0;
    dat_d    = dat_q;
    // RQ4: reserved and unmapped words answer err, no effect
    if (req && sel_reg == HRC_R_NONE)
      err_d = 1'b1;
    else if (req)
    begin
      ack_d = 1'b1;
      dat_d = 32'h0000_0000;
      case (sel_reg)
        HRC_R_PULL_UP_CONTROL_2: dat_d[7:0] = pull_up_control_2_q;
        HRC_R_PM0:  dat_d[7:0] = {4'h0, sw_rst_q, 1'b0, pm_q};
        HRC_R_STAT: dat_d[7:0] = {4'h0, ram_q, cause_q};
        HRC_R_PCR:  dat_d[7:0] = pcr_q;
        default:    dat_d[7:0] = 8'h00;
      endcase
      if (wr_lo)
      begin
        case (sel_reg)
          HRC_R_PULL_UP_CONTROL_2: pull_up_control_2_d = dat_i[7:0];
          HRC_R_PCR:  pcr_d  = dat_i[7:0];
          HRC_R_PM0:
          begin
            pm_d     = dat_i[1:0];
            sw_rst_d = dat_i[PM_SWR_B];
          end
          HRC_R_STAT:
            if (dat_i[ST_RAM_B])
              ram_d = 1'b0;
          default:
            ram_d = ram_q;
        endcase
      end
    end
    // RQ10: set beats a same-cycle clear
    if (state_q == HRC_RUN && hard_req && ram_wr_i)
      ram_d = 1'b1;
    // RQ9: no ram clear here, only the flag above
    if (state_q == HRC_REL)
    begin
      pull_up_control_2_d   = pull_up_control_2_rst;
      pcr_d    = PCR_RST;
      sw_rst_d = 1'b0;
      vec_d    = RESET_VEC;
      // RQ3: mode field survives soft resets
      if (hard_q)
        pm_d = PM_SINGLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pull_up_control_2_q   <= PULL_UP_CONTROL_2_LOW;
      pcr_q    <= PCR_RST;
      pm_q     <= PM_SINGLE;
      sw_rst_q <= 1'b0;
      ram_q    <= 1'b0;
      vec_q    <= '0;
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pull_up_control_2_q   <= pull_up_control_2_d;
      pcr_q    <= pcr_d;
      pm_q     <= pm_d;
      sw_rst_q <= sw_rst_d;
      ram_q    <= ram_d;
      vec_q    <= vec_d;
      ack_q    <= ack_d;
      err_q    <= err_d;
      dat_q    <= dat_d;
    end
  end

  assign dat_o                  = dat_q;
  assign ack_o                  = ack_q;
  assign err_o                  = err_q;
  assign fetch_addr_o           = vec_q;
  assign pull_up_control_2_o    = pull_up_control_2_q;
  assign port_control_o         = pcr_q;
  assign processor_mode_field_o = pm_q;
  assign ram_indet_o            = ram_q;

  // =========================================
  // assertions, stalled cycles skipped
  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (rst_i);

  sequence rel_s;
    state_q == HRC_REL && !hard_req;
  endsequence

  hard_pullup_a: assert property (rel_s and hard_q |=> pull_up_control_2_q == (boot_mode_pin_i ? 8'h02 : 8'h00)) // RQ2
    else $error("pull-up value wrong after hardware reset");
  soft_pullup_a: assert property (rel_s and !hard_q |=> pull_up_control_2_q == ((pm_q == 2'h1 || pm_q == 2'h3) ? 8'h02 : 8'h00)) // RQ3
    else $error("pull-up value wrong after soft reset");
  reserved_err_a: assert property (req && adr_i[11:2] == 10'h3ff |=> err_o && !ack_o) // RQ4
    else $error("reserved word not refused");
  pin_hold_a: assert property (!pin_s2_q && state_q == HRC_HOLD |-> pin_reset_o && osc_reset_o) // RQ5
    else $error("pins or oscillator not held in reset");
  osc_run_a: assert property (osc_reset_o |-> !osc_run_o) // RQ6
    else $error("oscillator running during reset");
  release_seq_a: assert property (rel_s |-> sfr_reset_o && cpu_reset_o ##1 fetch_o && !cpu_reset_o) // RQ7
    else $error("release order broken");
  fetch_vec_a: assert property (fetch_o |-> fetch_addr_o == RESET_VEC ##1 !fetch_o) // RQ8
    else $error("fetch address not reset vector");
  ram_flag_a: assert property (state_q == HRC_RUN && hard_req && ram_wr_i |=> ram_indet_o) // RQ10
    else $error("ram indeterminate flag missed");
  sync_rel_a: assert property ($rose(pin_s2_q) && !brownout_i && state_q == HRC_HOLD |=> state_q == HRC_REL) // RQ12
    else $error("release not one cycle after sync");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

endmodule

// [testbench/hrc_reset_src.sv]
// Purpose: external reset circuit driving the active-low reset pin
// Assumes: start_i is a one-cycle request from the bench
// Notes:   hold_i picks a prompt (20) or slow low time

`timescale 1ns/10ps

module hrc_reset_src
(
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] hold_i,
  output logic            reset_pin_n_o
);
  // ==========================================
  // low-time counter
  logic [7:0] cnt_q = 8'h00;

  always @(posedge clk_i)
  begin
    if (start_i)
      cnt_q <= (hold_i < 8'h14) ? 8'h14 : hold_i;  // never shorter than 20 clocks
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  assign reset_pin_n_o = (cnt_q == 8'h00);
endmodule

// [testbench/tb.sv]
// Purpose: self-checking bench for the reset sequencer
// Assumes: one 250 MHz clock, wishbone answer within a few cycles
// Notes:   expectations come from the package constants, the local VEC and literal values

`timescale 1ns/10ps

module tb
  import hrc_pkg::*;
;
  // ==========================================
  // signals
  localparam logic [19:0] VEC = 20'h0a5c4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin_n, boot = 1'b0, bor = 1'b0, wdt = 1'b0, osd = 1'b0, ramwr = 1'b0;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, go = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, err_o, e, pin_rst, osc_rst, osc_run, cpu_rst, sfr_rst, fetch_o, indet;
  logic [7:0]  hold = 8'h14;
  logic [19:0] faddr;
  logic [7:0]  pull_up_control_2, port_control;
  logic [1:0]  mode;
  int          fail_count = 0;
  int          n_checks = 0;

  always #2 clk_i = ~clk_i;

  hrc_reset_src u_hrc_reset_src (.clk_i(clk_i), .start_i(go), .hold_i(hold), .reset_pin_n_o(pin_n));

  hrc_reset_ctrl #(.VEC_W(20), .RESET_VEC(VEC)) u_hrc_reset_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .reset_pin_n_i(pin_n), .boot_mode_pin_i(boot),
    .brownout_i(bor), .wdt_reset_i(wdt), .osc_stop_i(osd), .ram_wr_i(ramwr), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .pin_reset_o(pin_rst), .osc_reset_o(osc_rst), .osc_run_o(osc_run),
    .cpu_reset_o(cpu_rst), .sfr_reset_o(sfr_rst), .fetch_o(fetch_o), .fetch_addr_o(faddr),
    .pull_up_control_2_o(pull_up_control_2), .port_control_o(port_control), .processor_mode_field_o(mode), .ram_indet_o(indet));

  // ==========================================
  // helpers
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask

  // one classic cycle, held until ack or err
  task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {idx, 2'b00}; sel_i <= 4'hf; dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    q = dat_o;
    e = err_o;
    if (n >= 50)
      fail_count++;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  // wait for the fetch pulse, noting the register reload pulse before it
  task automatic wait_fetch(input logic [7:0] xpur, input logic [2:0] cause);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
      if (sfr_rst === 1'b1)
        s = 1'b1;
    end
    while (fetch_o !== 1'b1 && n < 200);
    chk("sfr_before_fetch", s, 1'b1);
    chk("cpu_rst_fetch", cpu_rst, 1'b0);
    chk("fetch_addr", faddr, VEC);
    @(posedge clk_i);
    chk("pull_up_control_2", pull_up_control_2, xpur);
    chk("pcr_reset", port_control, 8'h00);
    wb(1'b0, STAT_IDX, 32'h0);
    chk("cause", q[2:0], cause);
  endtask

  task automatic pin_reset(input logic b, input logic rw, input logic [7:0] h);
    boot <= b; ramwr <= rw; hold <= h; go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("pin_rst", pin_rst, 1'b1);
    chk("osc_rst", {osc_rst, osc_run}, 2'b10);
    chk("cpu_rst", cpu_rst, 1'b1);
    ramwr <= 1'b0;
    wait_fetch(b ? PULL_UP_CONTROL_2_HIGH : PULL_UP_CONTROL_2_LOW, CAUSE_PIN);
    chk("ram_flag", indet, rw);
  endtask

  // ==========================================
  // watchdog: whole run is about 500 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end

  // ==========================================
  // tests
  initial
  begin
    logic [1:0] mt [4];
    mt = '{2'h2, PM_SINGLE, PM_EXPAND, PM_MPROC};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_fetch(PULL_UP_CONTROL_2_LOW, CAUSE_PIN);
    pin_reset(1'b0, 1'b0, 8'h14);
    pin_reset(1'b1, 1'b1, 8'h28);
    wb(1'b1, STAT_IDX, 32'h8);
    chk("ram_clear", indet, 1'b0);
    wb(1'b1, PCR_IDX, 32'h5a);
    wb(1'b0, PCR_IDX, 32'h0);
    chk("pcr_rw", q, 32'h5a);
    wb(1'b0, 10'h3ff, 32'h0);
    chk("reserved_err", e, 1'b1);
    // soft sources with every mode; boot pin high must not matter
    for (int i = 0; i < 4; i++)
      for (int s = 0; s < 3; s++)
      begin
        wb(1'b1, PM0_IDX, {30'h0, mt[i]});
        wb(1'b1, PCR_IDX, 32'ha5);
        if (s == 0)
          wb(1'b1, PM0_IDX, {28'h0, 4'h8} | {30'h0, mt[i]});
        else
        begin
          @(posedge clk_i);
          wdt <= (s == 1); osd <= (s == 2);
          @(posedge clk_i);
          wdt <= 1'b0; osd <= 1'b0;
        end
        wait_fetch((mt[i] == PM_EXPAND || mt[i] == PM_MPROC) ? PULL_UP_CONTROL_2_HIGH : PULL_UP_CONTROL_2_LOW,
                   (s == 0) ? CAUSE_SW : ((s == 1) ? CAUSE_WDT : CAUSE_OSD));
        chk("mode_kept", mode, mt[i]);
      end
    // brown-out acts as hard reset and clears the mode
    bor <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("bor_pin_rst", pin_rst, 1'b1);
    bor <= 1'b0;
    wait_fetch(PULL_UP_CONTROL_2_HIGH, CAUSE_BOR);
    chk("mode_clear", mode, PM_SINGLE);
    complete_run();
  end
endmodule
